// *** rtl/vpm_map.svh ***
// Purpose: Constants of the video port mode logic.
// Assumes: Included by the package and by the port top; guarded.
// Notes: Bytes travel low byte first inside a word.
// Contract
// (RL1) In output mode the port sends data and drives one, two or three frame syncs as set.
// (RL2) Receive offers three submodes: active video only, blanking only, entire field.
// (RL3) Active-video submode drops samples from end-of-video to start-of-video and in blanking.
// (RL4) Active-video submode strips the timing preamble bytes and never stores them.
// (RL5) Active-video submode, once locked to field 1, ignores samples until a start code.
// (RL6) Software sets the active line count before an active-video capture starts.
// (RL7) Blanking submode passes only samples inside vertical blanking and drops the rest.
// (RL8) Entire-field submode keeps every sample, preambles and ancillary data included.
// (RL9) Entire-field submode starts storing right after locking to field 1, no wait.
// (RL10) A timing code is FF 00 00 then a status byte with field, blanking and end bits.
`ifndef VPM_MAP_SVH
`define VPM_MAP_SVH
`define VPM_BYTE_W     8
`define VPM_WORD_W     64
`define VPM_IDX_W      3
`define VPM_CNT_W      12
`define VPM_FS_W       3
`define VPM_TRC_LEAD   8'hFF
`define VPM_TRC_ZERO   8'h00
`define VPM_ST_F_BIT   6
`define VPM_ST_V_BIT   5
`define VPM_ST_H_BIT   4
`define VPM_IDX_LAST   3'h7
`define VPM_IDLE_BYTE  8'h00
`define VPM_OE_N_RST   1'h1
`endif

// *** rtl/vpm_pkg.sv ***
// Purpose: Types shared by the video port mode logic.
// Assumes: vpm_map.svh gives the widths.
// Notes: Config is a bundle held steady while the port is enabled.
`include "vpm_map.svh"
`default_nettype none
package vpm_pkg;
    typedef logic [`VPM_BYTE_W-1:0] vpm_byte_t;
    typedef logic [`VPM_WORD_W-1:0] vpm_word_t;
    typedef logic [`VPM_CNT_W-1:0]  vpm_cnt_t;
    typedef enum logic {
        VPM_DIR_RX = 1'h0,
        VPM_DIR_TX = 1'h1
    } vpm_dir_e;
    typedef enum logic [1:0] {
        VPM_SUB_ACTIVE = 2'h0,
        VPM_SUB_VBI    = 2'h1,
        VPM_SUB_ENTIRE = 2'h2
    } vpm_sub_e;
    typedef enum logic [1:0] {
        VPM_HUNT = 2'h0,
        VPM_RUN  = 2'h1,
        VPM_DONE = 2'h2
    } vpm_rx_state_e;
    typedef struct packed {
        logic     fld;
        logic     vbl;
        logic     eav;
    } vpm_trc_s;
    typedef struct packed {
        logic     enable;
        vpm_dir_e dir;
        vpm_sub_e submode;
        logic [1:0] fs_count;
        vpm_cnt_t active_line_count_reg;
        vpm_cnt_t tx_samples;
        vpm_cnt_t tx_lines;
    } vpm_cfg_s;
endpackage
`default_nettype wire

// *** rtl/vpm_xing.sv ***
// Purpose: Passes one word at a time between two clock domains.
// Assumes: Toggle request and toggle acknowledge, two flops each way.
// Notes: Both resets must overlap for a few cycles of the slower clock.
`default_nettype none
module vpm_xing (
    // Source side
    input  wire logic               src_clk,
    input  wire logic               src_rst,
    input  wire logic               src_valid,
    output logic                    src_ready,
    input  wire vpm_pkg::vpm_word_t src_data,
    // Destination side
    input  wire logic               dst_clk,
    input  wire logic               dst_rst,
    output logic                    dst_valid,
    input  wire logic               dst_ready,
    output vpm_pkg::vpm_word_t      dst_data
);
    import vpm_pkg::*;
    logic      req_r;
    logic      req_nxt;
    vpm_word_t hold_r;
    vpm_word_t hold_nxt;
    logic      ack_m_r;
    logic      ack_s_r;
    logic      req_m_r;
    logic      req_s_r;
    logic      ack_r;
    logic      ack_nxt;

    // Hold stays still while a word is in flight, so the far side reads it safely
    assign src_ready = (req_r == ack_s_r);
    assign dst_valid = (req_s_r != ack_r);
    assign dst_data  = hold_r;

    always_comb begin
        req_nxt  = req_r;
        hold_nxt = hold_r;
        if (src_valid && src_ready) begin
            req_nxt  = ~req_r;
            hold_nxt = src_data;
        end
    end

    always_ff @(posedge src_clk) begin
        if (src_rst) begin
            req_r   <= 1'h0;
            hold_r  <= '0;
            ack_m_r <= 1'h0;
            ack_s_r <= 1'h0;
        end else begin
            req_r   <= req_nxt;
            hold_r  <= hold_nxt;
            ack_m_r <= ack_r;
            ack_s_r <= ack_m_r;
        end
    end

    always_comb begin
        ack_nxt = ack_r ^ (dst_valid & dst_ready);
    end

    always_ff @(posedge dst_clk) begin
        if (dst_rst) begin
            ack_r   <= 1'h0;
            req_m_r <= 1'h0;
            req_s_r <= 1'h0;
        end else begin
            ack_r   <= ack_nxt;
            req_m_r <= req_r;
            req_s_r <= req_m_r;
        end
    end
endmodule
`default_nettype wire

// *** rtl/vpm_video_port.sv ***
// Purpose: Mode logic of the parallel video port, receive and output.
// Assumes: Config steady while enabled; link clock runs while enabled.
// Notes: Words are 64 bits so one handshake crossing keeps up with the link.
`include "vpm_map.svh"
`default_nettype none
module vpm_video_port (
    // System clock and reset
    input  wire logic               clk,
    input  wire logic               rst,
    // Configuration
    input  wire vpm_pkg::vpm_cfg_s  cfg,
    // Received words toward DMA
    output logic                    rx_valid,
    input  wire logic               rx_ready,
    output vpm_pkg::vpm_word_t      rx_word,
    // Words to send, from DMA
    input  wire logic               tx_valid,
    output logic                    tx_ready,
    input  wire vpm_pkg::vpm_word_t tx_word,
    // Status
    output logic                    stat_locked,
    output logic                    stat_overrun,
    output logic                    stat_underrun,
    output logic                    frame_done,
    // Link pins
    input  wire logic               vp_clk,
    input  wire vpm_pkg::vpm_byte_t vp_data_in,
    output vpm_pkg::vpm_byte_t      vp_data_out,
    output logic                    vp_data_oe_n,
    output logic [`VPM_FS_W-1:0]    vp_fs
);
    import vpm_pkg::*;

    function automatic vpm_trc_s trc_decode(input vpm_byte_t b);
        vpm_trc_s t;
        t.fld = b[`VPM_ST_F_BIT];
        t.vbl = b[`VPM_ST_V_BIT];
        t.eav = b[`VPM_ST_H_BIT];
        return t;
    endfunction

    function automatic vpm_cnt_t wrap_inc(input vpm_cnt_t c, input vpm_cnt_t lim);
        logic [`VPM_CNT_W:0] s;
        s = {1'h0, c} + {{`VPM_CNT_W{1'h0}}, 1'h1};
        return (s >= {1'h0, lim}) ? '0 : s[`VPM_CNT_W-1:0];
    endfunction

    // System domain
    logic       off_r;
    logic       off_nxt;
    logic [2:0] st_m_r;
    logic [2:0] st_s_r;
    logic       dn_m_r;
    logic       dn_s_r;
    logic       dn_d_r;
    logic       fd_r;
    logic       fd_nxt;

    // Link domain reset and config
    logic      lrst_m_r;
    logic      lrst_r;
    vpm_cfg_s  lcfg_r;
    vpm_cfg_s  lcfg_nxt;
    vpm_byte_t din_r;

    // Receive path
    vpm_rx_state_e   state_r;
    vpm_rx_state_e   state_nxt;
    vpm_byte_t [2:0] hist_r;
    vpm_byte_t [2:0] hist_nxt;
    logic [2:0]      keep_r;
    logic [2:0]      keep_nxt;
    logic            seen_r;
    logic            seen_nxt;
    logic            fld_r;
    logic            fld_nxt;
    logic            vbl_r;
    logic            vbl_nxt;
    logic            act_r;
    logic            act_nxt;
    vpm_cnt_t        lines_r;
    vpm_cnt_t        lines_nxt;
    logic            done_t_r;
    logic            done_t_nxt;
    vpm_word_t       pack_r;
    vpm_word_t       pack_nxt;
    logic [2:0]      bcnt_r;
    logic [2:0]      bcnt_nxt;
    vpm_word_t       wrd_r;
    vpm_word_t       wrd_nxt;
    logic            wv_r;
    logic            wv_nxt;
    logic            ovr_r;
    logic            ovr_nxt;
    logic            rx_src_ready;
    logic            rx_mode;
    logic            trc;
    vpm_trc_s        st;
    logic            f1_start;
    logic            kill;
    logic            run;
    logic            k_new;
    logic            out_keep;

    // Output path
    vpm_cnt_t   scnt_r;
    vpm_cnt_t   scnt_nxt;
    vpm_cnt_t   lcnt_r;
    vpm_cnt_t   lcnt_nxt;
    vpm_word_t  sh_r;
    vpm_word_t  sh_nxt;
    logic [2:0] bidx_r;
    logic [2:0] bidx_nxt;
    logic       have_r;
    logic       have_nxt;
    logic       begun_r;
    logic       begun_nxt;
    logic       udr_r;
    logic       udr_nxt;
    vpm_byte_t  dout_r;
    vpm_byte_t  dout_nxt;
    logic [2:0] fs_r;
    logic [2:0] fs_nxt;
    logic       oe_n_r;
    logic       oe_n_nxt;
    logic       txm;
    logic [1:0] fsn;
    logic       tx_dst_valid;
    logic       tx_dst_ready;
    vpm_word_t  tx_dst_data;

    // System side: enable, status syncs, frame pulse
    always_comb begin
        off_nxt = rst | ~cfg.enable;
        fd_nxt  = dn_s_r ^ dn_d_r;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            off_r  <= 1'h1;
            st_m_r <= 3'h0;
            st_s_r <= 3'h0;
            dn_m_r <= 1'h0;
            dn_s_r <= 1'h0;
            dn_d_r <= 1'h0;
            fd_r   <= 1'h0;
        end else begin
            off_r  <= off_nxt;
            st_m_r <= {state_r != VPM_HUNT, ovr_r, udr_r};
            st_s_r <= st_m_r;
            dn_m_r <= done_t_r;
            dn_s_r <= dn_m_r;
            dn_d_r <= dn_s_r;
            fd_r   <= fd_nxt;
        end
    end

    assign stat_locked   = st_s_r[2];
    assign stat_overrun  = st_s_r[1];
    assign stat_underrun = st_s_r[0];
    assign frame_done    = fd_r;

    // Link reset follows the enable; config is frozen while it is released
    always_comb begin
        lcfg_nxt = lrst_r ? cfg : lcfg_r;
    end

    always_ff @(posedge vp_clk) begin
        lrst_m_r <= off_r;
        lrst_r   <= lrst_m_r;
        lcfg_r   <= lcfg_nxt;
        din_r    <= vp_data_in;
    end

    assign rx_mode = (lcfg_r.dir == VPM_DIR_RX);

    // Receive: timing code hunt, region tracking, sample selection
    always_comb begin
        trc = (hist_r[2] == `VPM_TRC_LEAD) && (hist_r[1] == `VPM_TRC_ZERO)
            && (hist_r[0] == `VPM_TRC_ZERO);                        // [RL10]
        st         = trc_decode(din_r);                             // [RL10]
        f1_start   = trc && seen_r && fld_r && !st.fld;
        state_nxt  = state_r;
        seen_nxt   = seen_r;
        fld_nxt    = fld_r;
        vbl_nxt    = vbl_r;
        act_nxt    = act_r;
        lines_nxt  = lines_r;
        done_t_nxt = done_t_r;
        if (trc) begin
            seen_nxt = 1'h1;
            fld_nxt  = st.fld;
            vbl_nxt  = st.vbl;
        end
        unique case (state_r)
            VPM_HUNT, VPM_DONE: begin
                if (f1_start) begin
                    state_nxt = VPM_RUN;
                    act_nxt   = 1'h0;                               // [RL5]
                    lines_nxt = '0;
                end
            end
            VPM_RUN: begin
                if (f1_start) begin
                    act_nxt   = 1'h0;
                    lines_nxt = '0;
                    if (lcfg_r.submode != VPM_SUB_ACTIVE) begin
                        done_t_nxt = ~done_t_r;
                    end
                end else if (trc && st.eav) begin
                    act_nxt = 1'h0;                                 // [RL3]
                    if (lcfg_r.submode == VPM_SUB_ACTIVE &&
                        lines_r == lcfg_r.active_line_count_reg) begin  // [RL6]
                        state_nxt  = VPM_DONE;
                        done_t_nxt = ~done_t_r;
                    end
                end else if (trc && !st.vbl) begin
                    act_nxt   = 1'h1;                               // [RL5]
                    lines_nxt = lines_r + 12'h1;
                end
            end
            default: begin
                state_nxt = VPM_HUNT;
            end
        endcase
        run  = rx_mode && (state_r == VPM_RUN);
        // Preamble is only known once complete, so three bytes wait in hist
        kill = trc && (lcfg_r.submode != VPM_SUB_ENTIRE);           // [RL4]
        unique case (lcfg_r.submode)                                // [RL2]
            VPM_SUB_ACTIVE: k_new = run && act_r && !vbl_r;         // [RL3]
            VPM_SUB_VBI:    k_new = run && vbl_r;                   // [RL7]
            default:        k_new = run;                            // [RL8] [RL9]
        endcase
        out_keep    = keep_r[2] && !kill;                           // [RL4]
        hist_nxt    = {hist_r[1:0], din_r};
        keep_nxt[2] = keep_r[1] && !kill;
        keep_nxt[1] = keep_r[0] && !kill;
        keep_nxt[0] = k_new && !kill;
    end

    // Receive: byte packing and hand-off to the crossing
    always_comb begin
        pack_nxt = pack_r;
        bcnt_nxt = bcnt_r;
        wrd_nxt  = wrd_r;
        wv_nxt   = wv_r;
        ovr_nxt  = ovr_r;
        if (wv_r && rx_src_ready) begin
            wv_nxt = 1'h0;
        end
        if (out_keep) begin
            pack_nxt[{bcnt_r, 3'h0} +: `VPM_BYTE_W] = hist_r[2];
            bcnt_nxt = bcnt_r + 3'h1;
            if (bcnt_r == `VPM_IDX_LAST) begin
                // No buffer: a word that finds the slot taken is lost
                if (wv_r && !rx_src_ready) begin
                    ovr_nxt = 1'h1;
                end else begin
                    wrd_nxt = pack_nxt;
                    wv_nxt  = 1'h1;
                end
            end
        end
    end

    always_ff @(posedge vp_clk) begin
        if (lrst_r) begin
            state_r  <= VPM_HUNT;
            hist_r   <= '0;
            keep_r   <= 3'h0;
            seen_r   <= 1'h0;
            fld_r    <= 1'h0;
            vbl_r    <= 1'h0;
            act_r    <= 1'h0;
            lines_r  <= '0;
            done_t_r <= 1'h0;
            pack_r   <= '0;
            bcnt_r   <= 3'h0;
            wrd_r    <= '0;
            wv_r     <= 1'h0;
            ovr_r    <= 1'h0;
        end else begin
            state_r  <= state_nxt;
            hist_r   <= hist_nxt;
            keep_r   <= keep_nxt;
            seen_r   <= seen_nxt;
            fld_r    <= fld_nxt;
            vbl_r    <= vbl_nxt;
            act_r    <= act_nxt;
            lines_r  <= lines_nxt;
            done_t_r <= done_t_nxt;
            pack_r   <= pack_nxt;
            bcnt_r   <= bcnt_nxt;
            wrd_r    <= wrd_nxt;
            wv_r     <= wv_nxt;
            ovr_r    <= ovr_nxt;
        end
    end

    // Output: line and frame counters, frame syncs, byte serialiser
    always_comb begin
        txm          = !rx_mode;
        fsn          = (lcfg_r.fs_count == 2'h0) ? 2'h1 : lcfg_r.fs_count;
        tx_dst_ready = txm && (!have_r || bidx_r == `VPM_IDX_LAST);
        scnt_nxt     = '0;
        lcnt_nxt     = '0;
        fs_nxt       = 3'h0;
        sh_nxt       = sh_r;
        bidx_nxt     = bidx_r;
        have_nxt     = have_r;
        begun_nxt    = begun_r;
        udr_nxt      = udr_r;
        dout_nxt     = `VPM_IDLE_BYTE;
        oe_n_nxt     = !txm;
        if (txm) begin
            scnt_nxt = wrap_inc(scnt_r, lcfg_r.tx_samples);
            lcnt_nxt = lcnt_r;
            if (scnt_nxt == '0) begin
                lcnt_nxt = wrap_inc(lcnt_r, lcfg_r.tx_lines);
            end
            fs_nxt[0] = (scnt_r == '0);                             // [RL1]
            fs_nxt[1] = (fsn >= 2'h2) && (scnt_r == '0) && (lcnt_r == '0);  // [RL1]
            fs_nxt[2] = (fsn == 2'h3) && (lcnt_r < (lcfg_r.tx_lines >> 1)); // [RL1]
            if (have_r) begin
                dout_nxt = sh_r[{bidx_r, 3'h0} +: `VPM_BYTE_W];
                bidx_nxt = bidx_r + 3'h1;
                if (bidx_r == `VPM_IDX_LAST) begin
                    have_nxt = 1'h0;
                end
            end else if (begun_r) begin
                udr_nxt = 1'h1;
            end
            if (tx_dst_ready && tx_dst_valid) begin
                sh_nxt    = tx_dst_data;
                bidx_nxt  = 3'h0;
                have_nxt  = 1'h1;
                begun_nxt = 1'h1;
            end
        end
    end

    always_ff @(posedge vp_clk) begin
        if (lrst_r) begin
            scnt_r  <= '0;
            lcnt_r  <= '0;
            sh_r    <= '0;
            bidx_r  <= 3'h0;
            have_r  <= 1'h0;
            begun_r <= 1'h0;
            udr_r   <= 1'h0;
            dout_r  <= `VPM_IDLE_BYTE;
            fs_r    <= 3'h0;
            oe_n_r  <= `VPM_OE_N_RST;
        end else begin
            scnt_r  <= scnt_nxt;
            lcnt_r  <= lcnt_nxt;
            sh_r    <= sh_nxt;
            bidx_r  <= bidx_nxt;
            have_r  <= have_nxt;
            begun_r <= begun_nxt;
            udr_r   <= udr_nxt;
            dout_r  <= dout_nxt;
            fs_r    <= fs_nxt;
            oe_n_r  <= oe_n_nxt;
        end
    end

    assign vp_data_out  = dout_r;
    assign vp_data_oe_n = oe_n_r;
    assign vp_fs        = fs_r;

    vpm_xing u_rx_xing (
        .src_clk   (vp_clk),
        .src_rst   (lrst_r),
        .src_valid (wv_r),
        .src_ready (rx_src_ready),
        .src_data  (wrd_r),
        .dst_clk   (clk),
        .dst_rst   (off_r),
        .dst_valid (rx_valid),
        .dst_ready (rx_ready),
        .dst_data  (rx_word)
    );

    vpm_xing u_tx_xing (
        .src_clk   (clk),
        .src_rst   (off_r),
        .src_valid (tx_valid),
        .src_ready (tx_ready),
        .src_data  (tx_word),
        .dst_clk   (vp_clk),
        .dst_rst   (lrst_r),
        .dst_valid (tx_dst_valid),
        .dst_ready (tx_dst_ready),
        .dst_data  (tx_dst_data)
    );
endmodule
`default_nettype wire

// *** dv/vpm_video_port_assertions.sv ***
// Purpose: Port-level checks of the video port mode logic.
// Assumes: Bound to vpm_video_port; sees its ports only.
// Notes: Link checks sleep while cfg.enable is low, as both domains are then reset.
`include "vpm_map.svh"
`default_nettype none
module vpm_video_port_checker (
    // Clocks and reset
    input wire logic                 clk,
    input wire logic                 rst,
    input wire logic                 vp_clk,
    // Config, DMA and status
    input wire vpm_pkg::vpm_cfg_s    cfg,
    input wire logic                 rx_valid,
    input wire logic                 rx_ready,
    input wire vpm_pkg::vpm_word_t   rx_word,
    input wire logic                 tx_valid,
    input wire logic                 tx_ready,
    input wire logic                 stat_locked,
    input wire logic                 stat_overrun,
    input wire logic                 frame_done,
    // Link outputs
    input wire logic                 vp_data_oe_n,
    input wire logic [`VPM_FS_W-1:0] vp_fs
);
    timeunit 1ns;
    timeprecision 100ps;
    import vpm_pkg::*;
    sequence take_s;
        rx_valid && rx_ready;
    endsequence
    sequence wait_s;
        rx_valid && !rx_ready;
    endsequence
    word_hold_a: assert property (@(posedge clk) disable iff (rst || !cfg.enable)
        wait_s |=> rx_valid && $stable(rx_word)) else $error("rx word moved while pending");
    word_take_a: assert property (@(posedge clk) disable iff (rst || !cfg.enable)
        take_s |=> !rx_valid) else $error("rx word not released");
    lock_first_a: assert property (@(posedge clk) disable iff (rst || !cfg.enable)
        rx_valid |-> stat_locked) else $error("word before lock");
    overrun_kept_a: assert property (@(posedge clk) disable iff (rst || !cfg.enable)
        stat_overrun |=> stat_overrun) else $error("overrun flag lost");
    frame_pulse_a: assert property (@(posedge clk) disable iff (rst || !cfg.enable)
        frame_done |=> !frame_done) else $error("frame end longer than a cycle");
    tx_take_a: assert property (@(posedge clk) disable iff (rst || !cfg.enable)
        tx_valid && tx_ready |=> !tx_ready) else $error("tx ready held after take");
    rx_no_drive_a: assert property (@(posedge vp_clk) disable iff (!cfg.enable)
        cfg.dir == VPM_DIR_RX |-> vp_data_oe_n) else $error("pins driven in receive");
    fs_single_a: assert property (@(posedge vp_clk) disable iff (!cfg.enable)
        cfg.fs_count < 2'h2 |-> vp_fs[2:1] == 2'h0) else $error("extra frame sync");
    fs_nested_a: assert property (@(posedge vp_clk) disable iff (!cfg.enable)
        vp_fs[1] |-> vp_fs[0] && cfg.fs_count != 2'h1) else $error("frame sync off line start");
    fs_pulse_a: assert property (@(posedge vp_clk) disable iff (!cfg.enable)
        vp_fs[0] && cfg.tx_samples > 12'h1 |=> !vp_fs[0]) else $error("line sync too long");
endmodule
bind vpm_video_port vpm_video_port_checker vpm_video_port_checker_inst (
    .clk, .rst, .vp_clk, .cfg, .rx_valid, .rx_ready, .rx_word, .tx_valid, .tx_ready,
    .stat_locked, .stat_overrun, .frame_done, .vp_data_oe_n, .vp_fs
);
`default_nettype wire

// *** dv/vpm_link_model.sv ***
// Purpose: Video source on the link data pins.
// Assumes: Bench calls its tasks; link clock runs free.
// Notes: Gaps carry the blank level, as a real source never floats the bus.
`default_nettype none
module vpm_link_model (
    // Link clock
    input  wire logic          vp_clk,
    // Data toward the port
    output vpm_pkg::vpm_byte_t vp_data_in
);
    timeunit 1ns;
    timeprecision 100ps;
    import vpm_pkg::*;
    initial vp_data_in = 8'h10;
    task automatic put(input vpm_byte_t b);
        @(posedge vp_clk);
        #10 vp_data_in = b;
    endtask
    task automatic code(input vpm_byte_t st);
        put(8'hFF);
        put(8'h00);
        put(8'h00);
        put(st);
    endtask
    task automatic blank(input int n);
        repeat (n) put(8'h10);
    endtask
endmodule
`default_nettype wire

// *** dv/vpm_video_port_tb_top.sv ***
// Purpose: Self-checking bench of the video port mode logic.
// Assumes: System clock 100 ns, link clock 160 ns, phases unrelated.
// Notes: Every scenario restarts the port through cfg.enable.
`include "vpm_map.svh"
`default_nettype none
module vpm_video_port_tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    import vpm_pkg::*;
    logic                 clk;
    logic                 rst;
    logic                 vp_clk;
    vpm_cfg_s             cfg;
    logic                 rx_valid;
    logic                 rx_ready;
    vpm_word_t            rx_word;
    logic                 tx_valid;
    logic                 tx_ready;
    vpm_word_t            tx_word;
    logic                 stat_locked;
    logic                 stat_overrun;
    logic                 stat_underrun;
    logic                 frame_done;
    vpm_byte_t            vp_data_in;
    vpm_byte_t            vp_data_out;
    logic                 vp_data_oe_n;
    logic [`VPM_FS_W-1:0] vp_fs;
    int                   miscompares;
    int                   checks_done;
    int                   done_cnt;
    vpm_video_port vpm_video_port_inst (
        .clk, .rst, .cfg, .rx_valid, .rx_ready, .rx_word, .tx_valid, .tx_ready,
        .tx_word, .stat_locked, .stat_overrun, .stat_underrun, .frame_done,
        .vp_clk, .vp_data_in, .vp_data_out, .vp_data_oe_n, .vp_fs
    );
    vpm_link_model vpm_link_model_inst (.vp_clk, .vp_data_in);
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    initial begin
        vp_clk = 1'b0;
        #37;
        forever #80 vp_clk = ~vp_clk;
    end
    always @(posedge clk) begin
        if (frame_done === 1'b1) done_cnt++;
    end
    task automatic check(input string what, input vpm_word_t seen, input vpm_word_t exp);
        checks_done++;
        if (seen !== exp) begin
            miscompares++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic complete_run();
        $display("Checks %0d, mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    task automatic restart(input vpm_dir_e dir, input vpm_sub_e sub, input logic [1:0] fs,
                           input vpm_cnt_t ns);
        @(posedge clk);
        #10 cfg.enable = 1'b0;
        repeat (6) @(posedge vp_clk);
        @(posedge clk);
        #10 cfg = '{1'b0, dir, sub, fs, 12'h001, ns, 12'(16 / ns)};
        repeat (4) @(posedge vp_clk);
        @(posedge clk);
        #10 cfg.enable = 1'b1;
        repeat (6) @(posedge vp_clk);
        if (dir == VPM_DIR_RX) begin
            vpm_link_model_inst.code(8'hF0);
            vpm_link_model_inst.code(8'hB0);
        end
    endtask
    task automatic get_word(output vpm_word_t w);
        int n;
        n = 0;
        w = '0;
        @(posedge clk);
        #10;
        while (rx_valid !== 1'b1 && n < 200) begin
            @(posedge clk);
            #10 n++;
        end
        if (n < 200) begin
            w = rx_word;
            rx_ready = 1'b1;
            @(posedge clk);
            #10 rx_ready = 1'b0;
        end
    endtask
    task automatic run_entire();
        vpm_word_t w;
        restart(VPM_DIR_RX, VPM_SUB_ENTIRE, 2'h1, 12'h004);
        vpm_link_model_inst.put(8'h21);
        vpm_link_model_inst.code(8'h80);
        vpm_link_model_inst.put(8'h22);
        vpm_link_model_inst.put(8'h23);
        vpm_link_model_inst.put(8'h24);
        vpm_link_model_inst.blank(30);
        @(posedge clk);
        #10 check("overrun", vpm_word_t'(stat_overrun), 64'h1);
        get_word(w);
        check("entire word", w, 64'h2423_2280_0000_FF21);
    endtask
    task automatic run_active();
        vpm_word_t w;
        int d0;
        restart(VPM_DIR_RX, VPM_SUB_ACTIVE, 2'h1, 12'h004);
        d0 = done_cnt;
        vpm_link_model_inst.blank(5);
        vpm_link_model_inst.code(8'h80);
        for (int i = 1; i <= 8; i++) vpm_link_model_inst.put(8'(8'h30 + i));
        vpm_link_model_inst.code(8'h90);
        vpm_link_model_inst.blank(12);
        get_word(w);
        check("active word", w, 64'h3837_3635_3433_3231);
        repeat (40) @(posedge clk);
        #10 check("after end", vpm_word_t'(rx_valid), 64'h0);
        check("frame end", vpm_word_t'(done_cnt - d0), 64'h1);
    endtask
    task automatic run_vbi();
        vpm_word_t w;
        restart(VPM_DIR_RX, VPM_SUB_VBI, 2'h1, 12'h004);
        for (int i = 1; i <= 8; i++) vpm_link_model_inst.put(8'(8'h40 + i));
        vpm_link_model_inst.code(8'h80);
        vpm_link_model_inst.blank(12);
        get_word(w);
        check("blank word", w, 64'h4847_4645_4443_4241);
        repeat (40) @(posedge clk);
        #10 check("after blanking", vpm_word_t'(rx_valid), 64'h0);
    endtask
    // Counts over one whole frame of 16 samples, so the start phase does not matter
    task automatic run_output(input logic [1:0] fs, input vpm_cnt_t ns);
        vpm_word_t w;
        int n;
        int c0;
        int c1;
        int c2;
        restart(VPM_DIR_TX, VPM_SUB_ACTIVE, fs, ns);
        tx_word = 64'h8877_6655_4433_2211;
        n = 0;
        @(posedge clk);
        #10;
        while (tx_ready !== 1'b1 && n < 50) begin
            @(posedge clk);
            #10 n++;
        end
        tx_valid = 1'b1;
        @(posedge clk);
        #10 tx_valid = 1'b0;
        w = '0;
        n = 0;
        while (vp_data_out === 8'h00 && n < 40) begin
            @(posedge vp_clk);
            #20 n++;
        end
        for (int i = 0; i < 8; i++) begin
            w[8*i +: 8] = vp_data_out;
            check("drive enable", vpm_word_t'(vp_data_oe_n), 64'h0);
            @(posedge vp_clk);
            #20;
        end
        check("sent word", w, 64'h8877_6655_4433_2211);
        c0 = 0;
        c1 = 0;
        c2 = 0;
        repeat (16) begin
            @(posedge vp_clk);
            #20 c0 += int'(vp_fs[0] === 1'b1);
            c1 += int'(vp_fs[1] === 1'b1);
            c2 += int'(vp_fs[2] === 1'b1);
        end
        check("line sync", vpm_word_t'(c0), 64'(16 / ns));
        check("frame sync", vpm_word_t'(c1), (fs >= 2'h2) ? 64'h1 : 64'h0);
        check("half sync", vpm_word_t'(c2), (fs == 2'h3) ? 64'h8 : 64'h0);
        @(posedge clk);
        #10 check("underrun", vpm_word_t'(stat_underrun), 64'h1);
    endtask
    initial begin
        rst = 1'b1;
        cfg = '0;
        rx_ready = 1'b0;
        tx_valid = 1'b0;
        tx_word = '0;
        miscompares = 0;
        checks_done = 0;
        done_cnt = 0;
        repeat (3) @(posedge clk);
        #10 rst = 1'b0;
        run_entire();
        run_active();
        run_vbi();
        for (int f = 1; f <= 3; f++) run_output(2'(f), 12'(1 << (f % 3 + 1)));
        complete_run();
    end
    initial begin
        #2000000;
        miscompares++;
        complete_run();
    end
endmodule
`default_nettype wire
